// *** include/bsc_pkg.sv ***
package bsc_pkg;

  localparam int          CHAIN_LEN   = 28;
  localparam int          GEN_LEN     = 6;
  localparam int          ADC_LEN     = 17;
  localparam int          DAC_W       = 10;
  localparam int          ADDR_W      = 12;
  localparam int          DATA_W      = 32;

  // chain bit positions, bit 0 is nearest tdo
  localparam int          IDX_GEN     = 0;
  localparam int          IDX_EXT_CLK = 6;
  localparam int          IDX_OSC_CLK = 7;
  localparam int          IDX_LF_CLK  = 8;
  localparam int          IDX_CMP_RES = 9;
  localparam int          IDX_COMP    = 10;
  localparam int          IDX_ADC     = 11;

  // level read on a clock line whose option is unused
  localparam logic        EXT_IDLE_LVL = 1'h0;
  localparam logic        OSC_IDLE_LVL = 1'h1;
  localparam logic        LF_IDLE_LVL  = 1'h1;

  localparam logic [11:0] OFS_CTRL    = 12'h000;
  localparam logic [11:0] OFS_STATUS  = 12'h004;
  localparam logic [11:0] OFS_CHAIN   = 12'h008;
  localparam logic [11:0] OFS_UPDATE  = 12'h00c;
  localparam int          CTRL_DRIVE  = 0;
  localparam int          STAT_DRIVE  = 0;
  localparam logic        CTRL_RST    = 1'h0;

  typedef struct packed {
    logic comparator_bandgap_enable;
    logic comparator_mux_select;
    logic comparator_off;
    logic lowfreq_osc_enable;
    logic main_osc_enable;
    logic ext_clock_input_enable;
  } bsc_gen_t;

  typedef struct packed {
    logic             neg_input_ground_enable;
    logic             external_channel_select;
    logic [DAC_W-1:0] dac_code;
    logic             gain_stage_power_on;
    logic             converter_power_on;
    logic             converter_bandgap_neg_enable;
    logic             gain_path_enable;
    logic             aclk;
  } bsc_adc_t;

  localparam bsc_gen_t GEN_RST = '0;

endpackage : bsc_pkg

// *** hdl/bsc_cells.sv ***
// Behaviour
// - each external oscillator enable sits in a drive-and-observe scan cell
// - oscillator clock outputs are captured by observe-only cells, never driven
// - low-frequency oscillator scanned like the main clock: enable cell, clock observed
// - internal rc oscillator output is not part of the chain
// - unused clock options read fixed: external 0, crystal 1, low-frequency 1
// - enables held in the chain so sleep logic cannot cut pins off
// - comparator idle, result, mux select and bandgap enable each get a cell
// - every adc digital/analog control and observe signal has a scan cell
// - adc comparator result reads low while the converter is powered off
// - adc cells are observe-only, capturing without driving
`timescale 1ns/10ps
`default_nettype none

module bsc_cells (
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic [bsc_pkg::ADDR_W-1:0]  paddr,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [bsc_pkg::DATA_W-1:0]  pwdata,
  output logic      [bsc_pkg::DATA_W-1:0]  prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        tck,
  input  wire logic                        tdi,
  input  wire logic                        scan_capture,
  input  wire logic                        scan_shift,
  input  wire logic                        scan_update,
  input  wire logic                        scan_extest,
  output logic                             tdo,
  input  wire bsc_pkg::bsc_gen_t           core_gen,
  output bsc_pkg::bsc_gen_t                gen_out,
  input  wire logic                        ext_clock_line,
  input  wire logic                        main_osc_clock,
  input  wire logic                        lowfreq_osc_clock,
  input  wire logic                        comparator_result,
  input  wire logic                        adc_comp,
  input  wire bsc_pkg::bsc_adc_t           adc_obs
);

  localparam int SYNC_W = 11;

  logic [SYNC_W-1:0]             sync1_r;
  logic [SYNC_W-1:0]             sync2_r;
  logic                          tck_d_r;
  logic                          tck_s;
  logic                          tdi_s;
  logic                          cap_s;
  logic                          shf_s;
  logic                          upd_s;
  logic                          ext_s;
  logic                          extc_s;
  logic                          osc_s;
  logic                          lf_s;
  logic                          cres_s;
  logic                          comp_s;
  logic                          tck_rise;
  logic [bsc_pkg::CHAIN_LEN-1:0] chain_r;
  logic [bsc_pkg::CHAIN_LEN-1:0] cap_val;
  bsc_pkg::bsc_gen_t             upd_r;
  bsc_pkg::bsc_gen_t             gen_out_r;
  logic                          drive_r;
  logic                          ctrl_drive_r;
  logic                          tdo_r;
  logic                          pready_r;
  logic                          pslverr_r;
  logic [bsc_pkg::DATA_W-1:0]    prdata_r;
  logic                          acc_done;

  ////////////////////////////////////////////////////////////////////
  // synchronisers: link pins and analog/osc lines are asynchronous

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      tck_d_r <= 1'h0;
    end else begin
      sync1_r <= {adc_comp, comparator_result, lowfreq_osc_clock, main_osc_clock,
                  ext_clock_line, scan_extest, scan_update, scan_shift,
                  scan_capture, tdi, tck};
      sync2_r <= sync1_r;
      tck_d_r <= tck_s;
    end
  end

  assign {comp_s, cres_s, lf_s, osc_s, extc_s, ext_s, upd_s, shf_s, cap_s, tdi_s,
          tck_s} = sync2_r;
  assign tck_rise = tck_s & ~tck_d_r;

  ////////////////////////////////////////////////////////////////////
  // capture values; rc oscillator has no cell at all

  always_comb begin
    cap_val = {adc_obs,
               comp_s & adc_obs.converter_power_on,
               cres_s & ~gen_out_r.comparator_off,
               gen_out_r.lowfreq_osc_enable ? lf_s  : bsc_pkg::LF_IDLE_LVL,
               gen_out_r.main_osc_enable    ? osc_s : bsc_pkg::OSC_IDLE_LVL,
               gen_out_r.ext_clock_input_enable ? extc_s : bsc_pkg::EXT_IDLE_LVL,
               gen_out_r};
  end

  ////////////////////////////////////////////////////////////////////
  // chain shift register, clocked by sampled tck rising edges

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      chain_r <= '0;
    end else if (tck_rise && cap_s) begin
      chain_r <= cap_val;
    end else if (tck_rise && shf_s) begin
      chain_r <= {tdi_s, chain_r[bsc_pkg::CHAIN_LEN-1:1]};
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tdo_r <= 1'h0;
    end else begin
      tdo_r <= chain_r[0];
    end
  end

  // only the general cells own an update stage; observe cells cannot drive
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      upd_r <= bsc_pkg::GEN_RST;
    end else if (tck_rise && upd_s) begin
      upd_r <= chain_r[bsc_pkg::IDX_GEN +: bsc_pkg::GEN_LEN];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // drive mux: scan value overrides core, incl. sleep gating

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      drive_r <= 1'h0;
    end else begin
      drive_r <= ctrl_drive_r & ext_s;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gen_out_r <= bsc_pkg::GEN_RST;
    end else begin
      gen_out_r <= drive_r ? upd_r : core_gen;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // apb slave, one wait state

  function automatic logic reg_known(input logic [bsc_pkg::ADDR_W-1:0] a);
    reg_known = (a == bsc_pkg::OFS_CTRL) || (a == bsc_pkg::OFS_STATUS) ||
                (a == bsc_pkg::OFS_CHAIN) || (a == bsc_pkg::OFS_UPDATE);
  endfunction : reg_known

  assign acc_done = psel & penable & pready_r;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready_r  <= 1'h0;
      pslverr_r <= 1'h0;
      prdata_r  <= '0;
    end else begin
      pready_r  <= psel & penable & ~pready_r;
      pslverr_r <= psel & penable & ~pready_r & ~reg_known(paddr);
      prdata_r  <= '0;
      if (psel && penable && !pready_r && !pwrite) begin
        case (paddr)
          bsc_pkg::OFS_CTRL:   prdata_r <= 32'(ctrl_drive_r);
          bsc_pkg::OFS_STATUS: prdata_r <= 32'(drive_r);
          bsc_pkg::OFS_CHAIN:  prdata_r <= 32'(chain_r);
          bsc_pkg::OFS_UPDATE: prdata_r <= 32'(upd_r);
          default:             prdata_r <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_drive_r <= bsc_pkg::CTRL_RST;
    end else if (acc_done && pwrite && paddr == bsc_pkg::OFS_CTRL) begin
      ctrl_drive_r <= pwdata[bsc_pkg::CTRL_DRIVE];
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign tdo     = tdo_r;
  assign gen_out = gen_out_r;

  ////////////////////////////////////////////////////////////////////
  // checks

  ext_idle_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    tck_rise && cap_s && !gen_out_r.ext_clock_input_enable
    |=> chain_r[bsc_pkg::IDX_EXT_CLK] == bsc_pkg::EXT_IDLE_LVL)
    else $error("unused external clock not read low");

  osc_idle_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    tck_rise && cap_s && !gen_out_r.main_osc_enable
    |=> chain_r[bsc_pkg::IDX_OSC_CLK] == bsc_pkg::OSC_IDLE_LVL)
    else $error("unused crystal clock not read high");

  lf_idle_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    tck_rise && cap_s && !gen_out_r.lowfreq_osc_enable
    |=> chain_r[bsc_pkg::IDX_LF_CLK] == bsc_pkg::LF_IDLE_LVL)
    else $error("unused low-frequency clock not read high");

  scan_drive_a: assert property (@(posedge clk) disable iff (sys_rst)
    drive_r |=> gen_out_r == $past(upd_r))
    else $error("driven enable does not follow update cell");

  core_pass_a: assert property (@(posedge clk) disable iff (sys_rst)
    !drive_r |=> gen_out_r == $past(core_gen))
    else $error("core enable not passed when not driving");

  adc_result_low_a: assert property (@(posedge clk) disable iff (sys_rst)
    tck_rise && cap_s && !adc_obs.converter_power_on
    |=> !chain_r[bsc_pkg::IDX_COMP])
    else $error("idle adc comparator result not low");

  adc_observe_a: assert property (@(posedge clk) disable iff (sys_rst)
    tck_rise && cap_s |=> chain_r[bsc_pkg::IDX_ADC +: bsc_pkg::ADC_LEN] == $past(adc_obs))
    else $error("adc signals not captured");

  cmp_idle_low_a: assert property (@(posedge clk) disable iff (sys_rst)
    tck_rise && cap_s && gen_out_r.comparator_off |=> !chain_r[bsc_pkg::IDX_CMP_RES])
    else $error("idle comparator result not low");

  shift_in_a: assert property (@(posedge clk) disable iff (sys_rst)
    tck_rise && shf_s && !cap_s |=> chain_r[bsc_pkg::CHAIN_LEN-1] == $past(tdi_s))
    else $error("chain did not shift in tdi");

  apb_wait_a: assert property (@(posedge clk) disable iff (sys_rst)
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb ready not one wait state");

  ext_line_obs_a: assert property (@(posedge clk) disable iff (sys_rst)
    tck_rise && cap_s && gen_out_r.ext_clock_input_enable
    |=> chain_r[bsc_pkg::IDX_EXT_CLK] == $past(extc_s))
    else $error("enabled external clock line not captured");

  osc_line_obs_a: assert property (@(posedge clk) disable iff (sys_rst)
    tck_rise && cap_s && gen_out_r.main_osc_enable
    |=> chain_r[bsc_pkg::IDX_OSC_CLK] == $past(osc_s))
    else $error("enabled crystal clock not captured");

  lf_line_obs_a: assert property (@(posedge clk) disable iff (sys_rst)
    tck_rise && cap_s && gen_out_r.lowfreq_osc_enable
    |=> chain_r[bsc_pkg::IDX_LF_CLK] == $past(lf_s))
    else $error("enabled low-frequency clock not captured");

  gen_cell_obs_a: assert property (@(posedge clk) disable iff (sys_rst)
    tck_rise && cap_s
    |=> chain_r[bsc_pkg::IDX_GEN +: bsc_pkg::GEN_LEN] == $past(gen_out_r))
    else $error("general cells do not capture driven enables");

  cmp_result_obs_a: assert property (@(posedge clk) disable iff (sys_rst)
    tck_rise && cap_s && !gen_out_r.comparator_off
    |=> chain_r[bsc_pkg::IDX_CMP_RES] == $past(cres_s))
    else $error("active comparator result not captured");

  adc_comp_obs_a: assert property (@(posedge clk) disable iff (sys_rst)
    tck_rise && cap_s && adc_obs.converter_power_on
    |=> chain_r[bsc_pkg::IDX_COMP] == $past(comp_s))
    else $error("powered adc comparator result not captured");

  update_load_a: assert property (@(posedge clk) disable iff (sys_rst)
    tck_rise && upd_s
    |=> upd_r == $past(chain_r[bsc_pkg::IDX_GEN +: bsc_pkg::GEN_LEN]))
    else $error("update stage not loaded from general cells");

  update_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !(tck_rise && upd_s)
    |=> upd_r == $past(upd_r))
    else $error("update stage changed outside an update");

  err_with_ready_a: assert property (@(posedge clk) disable iff (sys_rst)
    pslverr
    |-> pready)
    else $error("apb error without ready");

endmodule : bsc_cells

`default_nettype wire

// *** testbench/bsc_tester.sv ***
`timescale 1ns/10ps
`default_nettype none
// external scan controller; tck stands still between frames
module bsc_tester (
  output logic     tck,
  output logic     tdi,
  output logic     scan_capture,
  output logic     scan_shift,
  output logic     scan_update,
  output logic     scan_extest,
  input  wire logic tdo
);
  initial begin
    {tck, tdi, scan_capture, scan_shift, scan_update, scan_extest} = 6'h00;
  end
  task automatic pulse;
    tck = 1'h1;
    #62.5;
    tck = 1'h0;
    #62.5;
  endtask : pulse
  // capture, 28 shifts, update; tdo read one full tck period after each rise
  task automatic frame(input logic [27:0] din, input logic ext, output logic [27:0] dout);
    // quarter-ns offset keeps every link edge off a clk edge
    #0.25;
    scan_extest = ext;
    #250;
    scan_capture = 1'h1;
    pulse();
    scan_capture = 1'h0;
    scan_shift = 1'h1;
    for (int i = 0; i < 28; i++) begin
      dout[i] = tdo;
      tdi = din[i];
      pulse();
    end
    scan_shift = 1'h0;
    tdi = ~tdi;
    scan_update = 1'h1;
    pulse();
    scan_update = 1'h0;
  endtask : frame
endmodule : bsc_tester
`default_nettype wire

// *** testbench/boundary_scan_clock_analog_cells_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module boundary_scan_clock_analog_cells_bench;
  logic                clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0]         paddr;
  logic [31:0]         pwdata, prdata, rd;
  logic                tck, tdi, cap, shf, upd, ext, tdo, er;
  logic                ext_clock_line, main_osc_clock, lowfreq_osc_clock;
  logic                comparator_result, adc_comp;
  bsc_pkg::bsc_gen_t   core_gen, gen_out;
  bsc_pkg::bsc_adc_t   adc_obs;
  int                  err_total, cmp_count;
  bsc_cells u_bsc_cells (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tck(tck), .tdi(tdi), .scan_capture(cap),
    .scan_shift(shf), .scan_update(upd), .scan_extest(ext), .tdo(tdo),
    .core_gen(core_gen), .gen_out(gen_out), .ext_clock_line(ext_clock_line),
    .main_osc_clock(main_osc_clock), .lowfreq_osc_clock(lowfreq_osc_clock),
    .comparator_result(comparator_result), .adc_comp(adc_comp), .adc_obs(adc_obs));
  bsc_tester u_bsc_tester (.tck(tck), .tdi(tdi), .scan_capture(cap), .scan_shift(shf),
    .scan_update(upd), .scan_extest(ext), .tdo(tdo));
  always #4 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (err_total == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 20) begin
      err_total++;
      stop_test();
    end
  endtask : apb
  // lines: {adc comp, comparator result, lowfreq, main osc, ext clock}
  task automatic observe(input logic [5:0] g, input logic [16:0] a, input logic [4:0] l,
                         input logic x, input logic [27:0] exp, input logic [5:0] gexp);
    logic [27:0] dout;
    @(posedge clk);
    core_gen <= g;
    adc_obs <= a;
    {adc_comp, comparator_result, lowfreq_osc_clock, main_osc_clock, ext_clock_line} <= l;
    u_bsc_tester.frame(exp, x, dout);
    repeat (8) @(posedge clk);
    chk(32'(dout), 32'(exp));
    chk(32'(gen_out), 32'(gexp));
  endtask : observe
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    apb(1'h0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    chk(32'(er), 32'h0);
    apb(1'h1, 12'h004, 32'h1);
    apb(1'h0, 12'h004, 32'h0);
    chk(rd, 32'h0);
    chk(32'(er), 32'h0);
    apb(1'h0, 12'h010, 32'h0);
    chk(rd, 32'h0);
    chk(32'(er), 32'h1);
  endtask : t_regs
  // enabled lines show the pin, unused ones their fixed level
  task automatic t_observe;
    observe(6'h00, 17'h1555d, 5'h1f, 1'h0, {17'h1555d, 5'h1e, 6'h00}, 6'h00);
    // idle adc and comparator stimulus: mid-scale code, powers and paths low
    observe(6'h0f, 17'h04000, 5'h18, 1'h0,
            {17'h04000, 5'h00, 6'h0f}, 6'h0f);
    observe(6'h07, 17'h00000, 5'h07, 1'h0, {17'h00000, 5'h07, 6'h07}, 6'h07);
    // chain keeps the last shifted-in word after update
    apb(1'h0, 12'h008, 32'h0);
    chk(rd, 32'h000001c7);
    chk(32'(er), 32'h0);
  endtask : t_observe
  // one main source only while driving the enables
  task automatic t_drive;
    logic [27:0] dout;
    // preload a single main source before driving starts
    u_bsc_tester.frame({22'h0, 6'h0a}, 1'h0, dout);
    apb(1'h1, 12'h000, 32'h1);
    u_bsc_tester.frame({22'h0, 6'h0a}, 1'h1, dout);
    repeat (8) @(posedge clk);
    chk(32'(gen_out), 32'h0a);
    apb(1'h0, 12'h004, 32'h0);
    chk(rd, 32'h1);
    apb(1'h0, 12'h00c, 32'h0);
    chk(rd, 32'h0a);
    observe(6'h35, 17'h0, 5'h05, 1'h1, {17'h0, 5'h04, 6'h0a}, 6'h0a);
    observe(6'h35, 17'h0, 5'h05, 1'h0, {17'h0, 5'h07, 6'h35}, 6'h35);
  endtask : t_drive
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'h0;
    sys_rst = 1'h1;
    err_total = 0;
    cmp_count = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    core_gen = '0;
    adc_obs = '0;
    {adc_comp, comparator_result, lowfreq_osc_clock, main_osc_clock, ext_clock_line} = 5'h00;
    repeat (6) @(posedge clk);
    sys_rst <= 1'h0;
    t_regs();
    t_observe();
    t_drive();
    stop_test();
  end
endmodule : boundary_scan_clock_analog_cells_bench
`default_nettype wire
